// ### hw/smbus_cfg_pkg.sv
// Package of register offsets, bit positions and timing constants
package smbus_cfg_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hc1;
    localparam logic [7:0] CTL_ADDR = 8'hc0;
    // Configuration register bits
    localparam int CFG_EN = 7;
    localparam int CFG_INH = 6;
    localparam int CFG_BUSY = 5;
    localparam int CFG_SDA_HOLD_EXTEND = 4;
    localparam int CFG_TOE = 3;
    localparam int CFG_FTE = 2;
    localparam int CFG_CS_HI = 1;
    localparam int CFG_CS_LO = 0;
    // Control register bits
    localparam int CTL_MASTER = 7;
    localparam int CTL_TX = 6;
    localparam int CTL_STA = 5;
    localparam int CTL_STO = 4;
    localparam int CTL_ACK_REQUEST_FLAG = 3;
    localparam int CTL_ARB = 2;
    localparam int CTL_ACK = 1;
    localparam int CTL_SI = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Core clock rate in MHz, SDA delays in core clocks, overflow and bit counts
    localparam int CORE_CLK_MHZ = 40;
    localparam int HOLD_NORM_CLKS = 3;
    localparam int SETUP_EXT_CLKS = 11;
    localparam int HOLD_EXT_CLKS = 12;
    localparam int FREE_PERIODS = 10;
    localparam int BIT_OVERFLOWS = 3;
    localparam int BYTE_BITS = 8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_LOW = 3'b011,
        ST_HIGH = 3'b010,
        ST_STOP = 3'b110,
        ST_STALL = 3'b111
    } mst_state_e;
endpackage : smbus_cfg_pkg

// ### hw/smbus_line_if.sv
// Interface carrying synchronised bus line levels and events
`timescale 1ns/1ps
interface smbus_line_if;
    logic scl;
    logic sda;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    modport mon (output scl, sda, start_det, stop_det, scl_rise, scl_fall);
    modport use_side (input scl, sda, start_det, stop_det, scl_rise, scl_fall);
endinterface : smbus_line_if

// ### hw/smbus_line_mon.sv
// Pin synchroniser and START/STOP/edge detector
`timescale 1ns/1ps
module smbus_line_mon (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    smbus_line_if.mon lines
);
    logic [1:0] scl_sync_q, scl_sync_d;
    logic [1:0] sda_sync_q, sda_sync_d;
    logic scl_prev_q, sda_prev_q;

    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_i};
        sda_sync_d = {sda_sync_q[0], sda_i};
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    always_comb begin
        lines.scl = scl_sync_q[1];
        lines.sda = sda_sync_q[1];
        lines.scl_rise = scl_sync_q[1] & ~scl_prev_q;
        lines.scl_fall = ~scl_sync_q[1] & scl_prev_q;
        lines.start_det = scl_sync_q[1] & scl_prev_q & sda_prev_q
            & ~sda_sync_q[1];
        lines.stop_det = scl_sync_q[1] & scl_prev_q & ~sda_prev_q
            & sda_sync_q[1];
    end
endmodule : smbus_line_mon

// ### hw/smbus_overflow_sel.sv
// Clock-source overflow selector with timer overflow synchronisers
`timescale 1ns/1ps
module smbus_overflow_sel (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] ovf_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [3:0] s1_q, s2_q, s3_q;
    logic [3:0] rise;

    genvar g;
    for (g = 0; g < 4; g++) begin : g_sync
        // Overflows may come from a slower timer clock; count edges only
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= ovf_i[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
            end
        end
        assign rise[g] = s2_q[g] & ~s3_q[g];
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= rise[sel_i];
        end
    end
endmodule : smbus_overflow_sel

// ### hw/smbus_config_control.sv
// SMBus configuration, clocking and control/status logic
`timescale 1ns/1ps
module smbus_config_control
    import smbus_cfg_pkg::*;
#(
    parameter int FREE_COUNT = FREE_PERIODS
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] cfg_rdata_o,
    output logic [7:0] ctl_rdata_o,
    input wire logic hw_ack_enable_i,
    input wire logic addr_match_i,
    input wire logic [3:0] timer_ovf_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic timeout_reload_o,
    output logic timeout_count_o,
    output logic bus_free_o
);
    // Free counter is eight bits wide
    if (FREE_COUNT < 1 || FREE_COUNT > 255) begin : g_bad_free
        $error("FREE_COUNT out of range");
    end

    smbus_line_if lines ();
    logic tick;
    logic [7:0] cfg_q, cfg_d;
    logic master_q, master_d, tx_q, tx_d, sta_q, sta_d, sto_q, sto_d;
    logic ack_request_flag_q, ack_request_flag_d, arb_q, arb_d, ack_q, ack_d, si_q, si_d;
    logic inh_act_q, inh_act_d, ignore_q, ignore_d, busy_q, busy_d;
    logic [7:0] free_cnt_q, free_cnt_d;
    mst_state_e st_q, st_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [3:0] dly_q, dly_d;
    logic scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d;
    logic sda_pend_q, sda_pend_d, sda_val_q, sda_val_d;
    logic wr_cfg, wr_ctl, si_clr, enable;
    logic [3:0] hold_clks;

    smbus_line_mon u_mon (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lines(lines)
    );

    smbus_overflow_sel u_sel (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ovf_i(timer_ovf_i),
        .sel_i(cfg_q[CFG_CS_HI:CFG_CS_LO]),
        .tick_o(tick)
    );

    assign enable = cfg_q[CFG_EN];
    assign wr_cfg = reg_wr_i && reg_addr_i == CFG_ADDR;
    assign wr_ctl = reg_wr_i && reg_addr_i == CTL_ADDR;
    assign si_clr = wr_ctl && !reg_wdata_i[CTL_SI] && si_q;
    assign hold_clks = cfg_q[CFG_SDA_HOLD_EXTEND] ? 4'(HOLD_EXT_CLKS)
                                          : 4'(HOLD_NORM_CLKS);

    // Configuration and status flags
    always_comb begin
        cfg_d = cfg_q;
        master_d = master_q;
        tx_d = tx_q;
        sta_d = sta_q;
        sto_d = sto_q;
        ack_request_flag_d = ack_request_flag_q;
        arb_d = arb_q;
        ack_d = ack_q;
        si_d = si_q;
        inh_act_d = inh_act_q;
        ignore_d = ignore_q;
        busy_d = busy_q;
        free_cnt_d = free_cnt_q;
        if (wr_cfg) begin
            cfg_d = reg_wdata_i;
            cfg_d[CFG_BUSY] = cfg_q[CFG_BUSY];
        end
        if (wr_ctl) begin
            sta_d = reg_wdata_i[CTL_STA];
            sto_d = reg_wdata_i[CTL_STO] & master_q;
            ack_d = reg_wdata_i[CTL_ACK];
            si_d = reg_wdata_i[CTL_SI];
            if (si_clr) begin
                arb_d = 1'b0;
                ack_request_flag_d = 1'b0;
            end
        end
        // Bus busy tracking and free timeout
        if (lines.start_det) begin
            busy_d = 1'b1;
            free_cnt_d = '0;
            inh_act_d = cfg_q[CFG_INH];
            ignore_d = 1'b0;
            if (!inh_act_q && !master_q) begin
                sta_d = 1'b1;
            end
        end else if (lines.stop_det) begin
            busy_d = 1'b0;
            master_d = 1'b0;
            // Own STOP raises no interrupt: it would stall the idle bus
            if (!master_q && !ignore_q && !inh_act_q) begin
                sto_d = 1'b1;
                si_d = 1'b1;
            end
        end else if (!(lines.scl && lines.sda)) begin
            free_cnt_d = '0;
        end else if (cfg_q[CFG_FTE] && tick && busy_q) begin
            if (free_cnt_q >= 8'(FREE_COUNT)) begin
                busy_d = 1'b0;
            end else begin
                free_cnt_d = free_cnt_q + 8'h01;
            end
        end
        // Master events
        if (st_q == ST_START && st_d == ST_LOW) begin
            master_d = 1'b1;
            tx_d = 1'b1;
            si_d = 1'b1;
        end
        // Lost when our released SDA reads low during SCL high
        if (st_q == ST_HIGH && tx_q && lines.scl && !sda_drv_q
            && !sda_pend_q && !lines.sda && master_q
            && bit_q < 4'(BYTE_BITS)) begin
            arb_d = 1'b1;
            master_d = 1'b0;
            si_d = 1'b1;
        end
        if (st_q == ST_HIGH && st_d == ST_STALL) begin
            si_d = 1'b1;
            if (bit_q == 4'(BYTE_BITS) && !tx_q && !hw_ack_enable_i) begin
                ack_request_flag_d = 1'b1;
            end
            if (tx_q && bit_q == 4'(BYTE_BITS)) begin
                ack_d = ~lines.sda;
            end
        end
        // Slave address NACK handling
        if (!master_q && lines.scl_rise && bit_q == 4'(BYTE_BITS)
            && !addr_match_i && hw_ack_enable_i) begin
            ignore_d = 1'b1;
        end
        if (si_clr && ack_request_flag_q && !reg_wdata_i[CTL_ACK] && !master_q) begin
            ignore_d = 1'b1;
        end
        // STO flag drops when the STOP state returns to idle
        if (st_q == ST_STOP && st_d == ST_IDLE) begin
            sto_d = 1'b0;
        end
        if (!enable) begin
            master_d = 1'b0;
            si_d = 1'b0;
        end
    end

    // Master SCL generation: low one overflow, high two overflows
    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        bit_d = bit_q;
        scl_drv_d = scl_drv_q;
        unique case (st_q)
            ST_IDLE: begin
                scl_drv_d = 1'b0;
                if (enable && sta_q && !busy_q && tick) begin
                    st_d = ST_START;
                end
            end
            ST_START: begin
                if (tick) begin
                    st_d = ST_LOW;
                    scl_drv_d = 1'b1;
                    bit_d = '0;
                end
            end
            ST_LOW: begin
                scl_drv_d = 1'b1;
                if (tick) begin
                    st_d = ST_HIGH;
                    scl_drv_d = 1'b0;
                    ph_d = '0;
                end
            end
            ST_HIGH: begin
                // Wait for SCL actually high before counting: stretch
                if (lines.scl && tick) begin
                    ph_d = ph_q + 2'h1;
                    if (ph_q == 2'(BIT_OVERFLOWS - 2)) begin
                        bit_d = bit_q + 4'h1;
                        scl_drv_d = 1'b1;
                        if (bit_q == 4'(BYTE_BITS)) begin
                            st_d = ST_STALL;
                        end else begin
                            st_d = ST_LOW;
                        end
                    end
                end
            end
            ST_STALL: begin
                scl_drv_d = 1'b1;
                if (!si_q) begin
                    bit_d = '0;
                    st_d = sto_q ? ST_STOP : ST_LOW;
                end
            end
            ST_STOP: begin
                // SDA must be low before SCL rises, or no STOP is seen
                scl_drv_d = !sda_drv_q;
                if (tick && lines.scl) begin
                    st_d = ST_IDLE; // restart follows if start set
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (!enable || arb_q) begin
            st_d = ST_IDLE;
            scl_drv_d = 1'b0;
        end
    end

    // SDA drive with hold timing after each SCL fall
    always_comb begin
        sda_pend_d = sda_pend_q;
        sda_val_d = sda_val_q;
        sda_drv_d = sda_drv_q;
        dly_d = dly_q;
        if (wr_ctl && (ack_request_flag_q || hw_ack_enable_i) && !tx_q) begin
            sda_drv_d = reg_wdata_i[CTL_ACK];
        end
        if (lines.scl_fall) begin
            sda_pend_d = 1'b1;
            dly_d = hold_clks;
            if (st_q == ST_STOP) begin
                sda_val_d = 1'b1;
            end else if (!tx_q && bit_q == 4'(BYTE_BITS)) begin
                sda_val_d = ack_q && !inh_act_q && !ignore_q;
            end else begin
                sda_val_d = 1'b0;
            end
        end else if (sda_pend_q) begin
            if (dly_q == 4'h0) begin
                sda_pend_d = 1'b0;
                sda_drv_d = sda_val_q;
            end else begin
                dly_d = dly_q - 4'h1;
            end
        end
        if (st_q == ST_START) begin
            sda_drv_d = 1'b1;
        end
        if ((st_q == ST_STALL || st_q == ST_STOP) && sto_q && !sda_pend_q
            && !lines.scl && !lines.scl_fall) begin
            sda_drv_d = 1'b1;
        end
        if (st_q == ST_STOP && lines.scl && tick) begin
            sda_drv_d = 1'b0;
        end
        if (!enable) begin
            sda_drv_d = 1'b0;
            sda_pend_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
            {master_q, tx_q, sta_q, sto_q} <= 4'h0;
            {ack_request_flag_q, arb_q, ack_q, si_q} <= 4'h0;
            inh_act_q <= 1'b0;
            ignore_q <= 1'b0;
            busy_q <= 1'b0;
            free_cnt_q <= 8'h00;
            st_q <= ST_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            dly_q <= 4'h0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            sda_pend_q <= 1'b0;
            sda_val_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            {master_q, tx_q, sta_q, sto_q} <= {master_d, tx_d, sta_d, sto_d};
            {ack_request_flag_q, arb_q, ack_q, si_q} <= {ack_request_flag_d, arb_d, ack_d, si_d};
            inh_act_q <= inh_act_d;
            ignore_q <= ignore_d;
            busy_q <= busy_d;
            free_cnt_q <= free_cnt_d;
            st_q <= st_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            dly_q <= dly_d;
            scl_drv_q <= scl_drv_d;
            sda_drv_q <= sda_drv_d;
            sda_pend_q <= sda_pend_d;
            sda_val_q <= sda_val_d;
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= CFG_RESET;
            ctl_rdata_o <= CTL_RESET;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            timeout_reload_o <= 1'b0;
            timeout_count_o <= 1'b0;
            bus_free_o <= 1'b1;
        end else begin
            cfg_rdata_o <= {cfg_d[7:6], busy_d, cfg_d[4:0]};
            ctl_rdata_o <= {master_d, tx_d, sta_d, sto_d,
                            ack_request_flag_d, arb_d, ack_d, si_d};
            scl_o <= 1'b0;
            scl_oe_o <= scl_drv_d || (si_d && enable);
            sda_o <= 1'b0;
            sda_oe_o <= sda_drv_d;
            timeout_reload_o <= cfg_q[CFG_TOE] && lines.scl;
            timeout_count_o <= cfg_q[CFG_TOE] && !lines.scl;
            bus_free_o <= !busy_d;
        end
    end
endmodule : smbus_config_control

// ### tb/smbus_config_control_sva.sv
// Port-level checks for the configuration and control block
`timescale 1ns/1ps
module smbus_config_control_sva
    import smbus_cfg_pkg::*;
#(
    parameter int FREE_COUNT = FREE_PERIODS
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic [7:0] ctl_rdata_o,
    input wire logic hw_ack_enable_i,
    input wire logic addr_match_i,
    input wire logic [3:0] timer_ovf_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic timeout_reload_o,
    input wire logic timeout_count_o,
    input wire logic bus_free_o
);
    // Generous: covers a small free count plus synchroniser lag
    localparam int FREE_WAIT = 200;
    logic wr_ctl;
    assign wr_ctl = reg_wr_i && reg_addr_i == CTL_ADDR;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    disabled_idle_a: assert property (
        !cfg_rdata_o[CFG_EN] [*2] |-> !scl_oe_o && !sda_oe_o)
        else $error("bus driven while disabled");
    si_stall_a: assert property (
        (ctl_rdata_o[CTL_SI] && ctl_rdata_o[CTL_MASTER]) [*2] |-> scl_oe_o)
        else $error("clock released while flag set");
    toe_reload_a: assert property (
        (cfg_rdata_o[CFG_TOE] && scl_i) [*5]
        |-> timeout_reload_o && !timeout_count_o)
        else $error("timer not reloading with clock high");
    toe_count_a: assert property (
        (cfg_rdata_o[CFG_TOE] && !scl_i) [*5]
        |-> timeout_count_o && !timeout_reload_o)
        else $error("timer not counting with clock low");
    sto_refuse_a: assert property (
        wr_ctl && reg_wdata_i[CTL_STO] && !ctl_rdata_o[CTL_MASTER]
        && !ctl_rdata_o[CTL_STO] |=> !ctl_rdata_o[CTL_STO])
        else $error("stop accepted outside master mode");
    start_master_a: assert property (
        wr_ctl && reg_wdata_i[CTL_STA] && cfg_rdata_o[CFG_EN] && bus_free_o
        |=> ctl_rdata_o[CTL_STA] ##[0:400] ctl_rdata_o[CTL_MASTER])
        else $error("start request did not make a master");
    arb_clear_a: assert property (
        $fell(ctl_rdata_o[CTL_SI])
        |-> !ctl_rdata_o[CTL_ARB] && !ctl_rdata_o[CTL_ACK_REQUEST_FLAG])
        else $error("flags kept after interrupt clear");
    scl_low_a: assert property (
        $rose(scl_oe_o) && ctl_rdata_o[CTL_MASTER] |-> scl_oe_o [*7])
        else $error("clock low phase too short");
    bus_free_a: assert property (
        cfg_rdata_o[CFG_FTE] && scl_i && sda_i && !bus_free_o
        |-> ##[1:FREE_WAIT] (bus_free_o || !scl_i || !sda_i))
        else $error("bus not freed after idle lines");
endmodule : smbus_config_control_sva

bind smbus_config_control smbus_config_control_sva #(
    .FREE_COUNT(FREE_COUNT)) u_sva (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .cfg_rdata_o(cfg_rdata_o),
    .ctl_rdata_o(ctl_rdata_o), .hw_ack_enable_i(hw_ack_enable_i),
    .addr_match_i(addr_match_i), .timer_ovf_i(timer_ovf_i),
    .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .timeout_reload_o(timeout_reload_o),
    .timeout_count_o(timeout_count_o), .bus_free_o(bus_free_o));

// ### tb/smbus_peer_model.sv
// Other bus party: pull-ups, clock stretching, contention and slave ACK
`timescale 1ns/1ps
module smbus_peer_model (
    input wire logic dut_scl_oe_i,
    input wire logic dut_sda_oe_i,
    input wire logic hold_scl_i,
    input wire logic pull_sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic [3:0] bit_q = 4'h0;
    logic ack_q = 1'b0;
    // Open drain: a released line floats up to the pull-up level
    assign scl_o = !(dut_scl_oe_i || hold_scl_i);
    assign sda_o = !(dut_sda_oe_i || pull_sda_i || ack_q);
    always @(negedge sda_o) begin
        if (scl_o) begin
            bit_q = 4'h0;
        end
    end
    // Ninth low phase of each byte is the acknowledge slot
    always @(negedge scl_o) begin
        bit_q = (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
        ack_q = (bit_q == 4'h9);
    end
endmodule : smbus_peer_model

// ### tb/smbus_config_control_bench.sv
// Register-level bench for the configuration and control block
`timescale 1ns/1ps
module smbus_config_control_bench;
    import smbus_cfg_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic hw_ack_enable_i = 1'b0;
    logic addr_match_i = 1'b0;
    logic ovf_clk = 1'b0;
    logic [3:0] ovf_mask = 4'h1;
    logic hold_scl = 1'b0;
    logic pull_sda = 1'b0;
    logic [7:0] cfg_rdata_o;
    logic [7:0] ctl_rdata_o;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_i, sda_i;
    logic timeout_reload_o, timeout_count_o, bus_free_o;
    int err_total = 0;
    int n_tests = 0;
    int t;
    int hi;
    int lo;
    wire [3:0] timer_ovf_i = ovf_clk ? ovf_mask : 4'h0;
    always #12.5 core_clk_i = ~core_clk_i;
    initial #37 forever #100 ovf_clk = ~ovf_clk;
    smbus_config_control #(.FREE_COUNT(2)) dut (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .cfg_rdata_o(cfg_rdata_o),
        .ctl_rdata_o(ctl_rdata_o), .hw_ack_enable_i(hw_ack_enable_i),
        .addr_match_i(addr_match_i), .timer_ovf_i(timer_ovf_i),
        .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .timeout_reload_o(timeout_reload_o),
        .timeout_count_o(timeout_count_o), .bus_free_o(bus_free_o));
    smbus_peer_model peer (.dut_scl_oe_i(scl_oe_o), .dut_sda_oe_i(sda_oe_o),
        .hold_scl_i(hold_scl), .pull_sda_i(pull_sda), .scl_o(scl_i),
        .sda_o(sda_i));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc;
        @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        cyc();
    endtask : wr
    task automatic wait_ctl(input int b, input logic v, input int lim);
        t = 0;
        while (ctl_rdata_o[b] !== v && t < lim) begin
            cyc();
            t++;
        end
        check(ctl_rdata_o[b], v, "control bit");
    endtask : wait_ctl
    // SI may come back after each further byte until the stop is sent
    task automatic stop_xfer;
        t = 0;
        while (ctl_rdata_o[CTL_MASTER] !== 1'b0 && t < 3000) begin
            if (ctl_rdata_o[CTL_SI] === 1'b1) wr(CTL_ADDR, 8'h10);
            cyc();
            t++;
        end
        check(ctl_rdata_o[CTL_MASTER], 1'b0, "master after stop");
        check({scl_i, sda_i}, 2'b11, "lines after stop");
    endtask : stop_xfer
    task automatic results;
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #2400000;
        err_total++;
        results();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        cyc();
        check({cfg_rdata_o, ctl_rdata_o}, {CFG_RESET, CTL_RESET}, "reset");
        check({bus_free_o, scl_oe_o, sda_oe_o, scl_o, sda_o}, 5'b10000,
            "reset pins");
        wr(CFG_ADDR, 8'hff);
        wr(8'hc3, 8'h00);
        check(cfg_rdata_o, 8'hdf, "config readback");
        wr(CTL_ADDR, 8'h10);
        check(ctl_rdata_o, 8'h00, "stop as slave");
        check({timeout_reload_o, timeout_count_o}, 2'b10, "timer high");
        hold_scl <= 1'b1;
        repeat (20) cyc();
        check({timeout_reload_o, timeout_count_o}, 2'b01, "timer low");
        hold_scl <= 1'b0;
        wr(CFG_ADDR, 8'h04);
        wr(CTL_ADDR, 8'h20);
        repeat (100) cyc();
        check({scl_oe_o, sda_oe_o}, 2'b00, "disabled bus");
        wr(CTL_ADDR, 8'h00);
        for (int s = 0; s < 4; s++) begin
            ovf_mask <= 4'h1 << ((s + 1) % 4);
            wr(CFG_ADDR, 8'h84 | 8'(s));
            wr(CTL_ADDR, 8'h20);
            repeat (200) cyc();
            check(ctl_rdata_o[CTL_MASTER], 1'b0, "other source");
            ovf_mask <= 4'h1 << s;
            wait_ctl(CTL_SI, 1'b1, 400);
            check(ctl_rdata_o[7:5], 3'b111, "start status");
            repeat (40) cyc();
            check(scl_i, 1'b0, "stall");
            wr(CTL_ADDR, 8'h00);
            hi = 0;
            lo = 0;
            t = 0;
            while (scl_i !== 1'b1 && t < 500) begin
                cyc();
                t++;
            end
            // First high after the stall depends on the tick phase
            while (scl_i !== 1'b0 && t < 500) begin
                cyc();
                t++;
            end
            while (scl_i !== 1'b1 && t < 500) begin
                cyc();
                t++;
            end
            while (scl_i === 1'b1 && hi < 500) begin
                cyc();
                hi++;
            end
            while (scl_i === 1'b0 && lo < 500) begin
                cyc();
                lo++;
            end
            check(hi >= 15 && hi <= 17 && lo >= 7 && lo <= 9, 1, "phases");
            wait_ctl(CTL_SI, 1'b1, 600);
            check(ctl_rdata_o[CTL_ACK], 1'b1, "ack received");
            stop_xfer();
        end
        pull_sda <= 1'b1;
        repeat (10) cyc();
        hold_scl <= 1'b1;
        repeat (10) cyc();
        pull_sda <= 1'b0;
        repeat (10) cyc();
        hold_scl <= 1'b0;
        repeat (4) cyc();
        check({bus_free_o, cfg_rdata_o[CFG_BUSY]}, 2'b01, "busy");
        wr(CTL_ADDR, 8'h20);
        check(ctl_rdata_o[CTL_MASTER], 1'b0, "start waits");
        wait_ctl(CTL_MASTER, 1'b1, 300);
        stop_xfer();
        results();
    end
endmodule : smbus_config_control_bench
